// [verilog/tcu_pkg.sv]
// Package: field layout, reset values and timing for the tape command word upper byte
package tcu_pkg;
    localparam int CLK_MHZ = 40;
    localparam int CLR_PULSE_NS = 1000;
    localparam int CLR_PULSE_CYC = (CLR_PULSE_NS * CLK_MHZ) / 1000;
    localparam logic [5:0] CLR_CNT_W_MAX = 6'(CLR_PULSE_CYC);
    localparam int BIT_ERR = 15;
    localparam int BIT_DEN_HI = 14;
    localparam int BIT_DEN_LO = 13;
    localparam int BIT_CLR = 12;
    localparam int BIT_EVEN_PARITY_CHOICE = 11;
    localparam int BIT_UNIT_HI = 10;
    localparam int BIT_UNIT_LO = 8;
    localparam logic [1:0] DEN_RST = 2'h0;
    localparam logic PAR_RST = 1'h0;
    localparam logic [2:0] UNIT_RST = 3'h0;
    localparam logic [2:0] FN_SPACE_FWD = 3'h4;
    localparam logic [2:0] FN_SPACE_REV = 3'h5;
    localparam logic [2:0] FN_REWIND = 3'h7;
    typedef enum logic [3:0] {
        DENS_200 = 4'h1,
        DENS_556 = 4'h2,
        DENS_800 = 4'h4,
        DENS_DUMP = 4'h8
    } tcu_dens_e;
endpackage

// [verilog/tcu_clear_pulse.sv]
// Fixed-length master clear pulse generator
`timescale 1ns/10ps
module tcu_clear_pulse (
    input wire logic clk_i,            // Clock
    input wire logic rst_n_i,          // Sync reset
    input wire logic trig_i,           // Start pulse
    output logic pulse_o               // Clear strobe level
);
    import tcu_pkg::*;
    logic [5:0] cnt_q, cnt_d;
    always_comb begin
        cnt_d = cnt_q;
        if (trig_i) begin
            cnt_d = CLR_CNT_W_MAX;
        end else if (cnt_q != 6'h0) begin
            cnt_d = cnt_q - 6'h1;
        end
    end
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            cnt_q <= 6'h0;
        end else begin
            cnt_q <= cnt_d;
        end
    end
    assign pulse_o = (cnt_q != 6'h0);
endmodule

// [verilog/tcu_cmd_upper.sv]
// Upper byte of the tape command word: error summary, density, clear, parity, unit
// Function
// - Error summary is the OR of status bits 15 down to 07.
// - Error summary set with irq permit requests an interrupt.
// - Deferred errors reach the summary only after the check character is read.
// - Summary cleared by initialize and by the next start command.
// - Density bits 14,13 select 200, 556, 800 bpi or 800 bpi.
// - Both density bits: nine-track 800 bpi, seven-track core dump.
// - Writing one to bit 12 resets controller and all drives.
// - Clear strobe lasts 1 us, only on write with data bit one.
// - Clear strobe bit always reads as zero.
// - Bit 11 one selects even parity, zero odd parity.
// - Parity checked while tape moves, ignored on spaces and rewind.
// - Parity bit cleared by initialize or writing zero.
// - Bits 10 to 08 hold drive number, cleared by initialize or zeros.
// - Interrupt permitted only while controller idle or illegal command set.
// - Status errors cleared by initialize or start pulse, clearing summary.
`timescale 1ns/10ps
module tcu_cmd_upper (
    input wire logic SYS_CLK_I,              // 40 MHz clock
    input wire logic RESETN_I,               // Bus initialize, active low
    input wire logic WR_HI_I,                // Processor write of upper byte
    input wire logic [15:8] WDATA_I,         // Write data upper byte
    output logic [15:8] RDATA_O,             // Read data upper byte
    input wire logic START_I,                // Start command pulse
    input wire logic IRQ_PERMIT_I,           // Interrupt enable bit
    input wire logic CONTROLLER_IDLE_I,      // Controller ready bit
    input wire logic ILLEGAL_COMMAND_FLAG_I, // Illegal command status flag
    input wire logic [8:0] ERR_NOW_I,        // Status errors 15..07, immediate kind
    input wire logic [8:0] ERR_DEFER_I,      // Status errors 15..07, deferred kind
    input wire logic CHECK_CHAR_I,           // Check character read pulse
    input wire logic SEVEN_TRACK_FLAG_I,     // Seven-track status flag
    input wire logic TAPE_MOVING_I,          // Tape in motion
    input wire logic [2:0] FUNCTION_I,       // Current function code
    input wire logic PARITY_ERR_I,           // Raw parity error from read path
    output logic IRQ_O,                      // Interrupt request pulse
    output logic PARITY_ERR_O,               // Qualified parity error
    output logic [3:0] DENSITY_O,            // One-hot density select
    output logic EVEN_PARITY_CHOICE_O,       // Even parity select to drive
    output logic [2:0] UNIT_O,               // Drive number to drives
    output logic MASTER_CLEAR_STROBE_O       // Clear to controller and drives
);
    import tcu_pkg::*;

    // ------------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------------
    logic [1:0] den_q, den_d;
    logic par_q, par_d;
    logic [2:0] unit_q, unit_d;
    logic [8:0] held_q, held_d;
    logic err_q, err_d;
    logic [3:0] dens_q, dens_d;
    logic [7:0] rd_q, rd_d;
    logic clr_trig;
    logic clr_level;
    logic ctl_rst_n;
    logic irq_gate;
    logic parity_watched;

    // ------------------------------------------------------------------
    // Decode functions
    // ------------------------------------------------------------------
    function automatic logic any_set(input logic [8:0] v);
        return v != 9'h000;
    endfunction

    function automatic logic [3:0] dens_decode(input logic [1:0] d, input logic seven);
        logic [3:0] r;
        r = DENS_800;
        unique case (d)
            2'h0: r = DENS_200;
            2'h1: r = DENS_556;
            2'h2: r = DENS_800;
            2'h3: r = seven ? DENS_DUMP : DENS_800;
        endcase
        return r;
    endfunction

    // ------------------------------------------------------------------
    // Master clear strobe
    // ------------------------------------------------------------------
    assign clr_trig = WR_HI_I && WDATA_I[BIT_CLR];
    // Clear strobe also resets our own state, like initialize
    assign ctl_rst_n = RESETN_I && !clr_level;

    // Counter sees bus initialize only, so a clear cannot cut itself short
    tcu_clear_pulse u_clr (
        .clk_i(SYS_CLK_I),
        .rst_n_i(RESETN_I),
        .trig_i(clr_trig),
        .pulse_o(clr_level)
    );

    // Limitation: a write landing during the strobe is lost to the clear
    assign MASTER_CLEAR_STROBE_O = clr_level;

    // ------------------------------------------------------------------
    // Density field
    // ------------------------------------------------------------------
    always_comb begin
        den_d = den_q;
        if (WR_HI_I) begin
            den_d = WDATA_I[BIT_DEN_HI:BIT_DEN_LO];
        end
    end

    always_ff @(posedge SYS_CLK_I) begin
        if (!ctl_rst_n) begin
            den_q <= DEN_RST;
        end else begin
            den_q <= den_d;
        end
    end

    // ------------------------------------------------------------------
    // Parity sense field
    // ------------------------------------------------------------------
    always_comb begin
        par_d = par_q;
        if (WR_HI_I) begin
            par_d = WDATA_I[BIT_EVEN_PARITY_CHOICE];
        end
    end

    always_ff @(posedge SYS_CLK_I) begin
        if (!ctl_rst_n) begin
            par_q <= PAR_RST;
        end else begin
            par_q <= par_d;
        end
    end

    // ------------------------------------------------------------------
    // Drive number field
    // ------------------------------------------------------------------
    always_comb begin
        unit_d = unit_q;
        if (WR_HI_I) begin
            unit_d = WDATA_I[BIT_UNIT_HI:BIT_UNIT_LO];
        end
    end

    always_ff @(posedge SYS_CLK_I) begin
        if (!ctl_rst_n) begin
            unit_q <= UNIT_RST;
        end else begin
            unit_q <= unit_d;
        end
    end

    // ------------------------------------------------------------------
    // Error summary
    // ------------------------------------------------------------------
    // Deferred errors are latched here until the check character arrives
    always_comb begin
        held_d = held_q | ERR_DEFER_I;
        err_d = err_q;
        // Start clears first; an immediate error in the same cycle sets again
        if (START_I) begin
            held_d = ERR_DEFER_I;
            err_d = 1'b0;
        end
        if (CHECK_CHAR_I && any_set(held_d)) begin
            err_d = 1'b1;
        end
        if (any_set(ERR_NOW_I)) begin
            err_d = 1'b1;
        end
    end

    always_ff @(posedge SYS_CLK_I) begin
        if (!ctl_rst_n) begin
            held_q <= 9'h000;
            err_q <= 1'b0;
        end else begin
            held_q <= held_d;
            err_q <= err_d;
        end
    end

    // ------------------------------------------------------------------
    // Interrupt
    // ------------------------------------------------------------------
    // Rising edge of the summary only; a clear in progress masks it
    assign irq_gate = IRQ_PERMIT_I && (CONTROLLER_IDLE_I || ILLEGAL_COMMAND_FLAG_I);
    assign IRQ_O = ctl_rst_n && err_d && !err_q && irq_gate;

    // ------------------------------------------------------------------
    // Parity check
    // ------------------------------------------------------------------
    // Spacing and rewind pass records unread, so no check there
    assign parity_watched = TAPE_MOVING_I && (FUNCTION_I != FN_SPACE_FWD) &&
        (FUNCTION_I != FN_SPACE_REV) && (FUNCTION_I != FN_REWIND);
    assign PARITY_ERR_O = PARITY_ERR_I && parity_watched;

    // ------------------------------------------------------------------
    // Output registers
    // ------------------------------------------------------------------
    // Fed from the next values, so reads still follow the write edge
    always_comb begin
        dens_d = dens_decode(den_d, SEVEN_TRACK_FLAG_I);
        rd_d = {err_d, den_d, 1'b0, par_d, unit_d};
    end

    // One more flop stage, traded for glitch-free data outputs
    always_ff @(posedge SYS_CLK_I) begin
        if (!ctl_rst_n) begin
            dens_q <= DENS_200;
            rd_q <= {1'b0, DEN_RST, 1'b0, PAR_RST, UNIT_RST};
        end else begin
            dens_q <= dens_d;
            rd_q <= rd_d;
        end
    end

    assign DENSITY_O = dens_q;
    // Clear position always reads zero
    assign RDATA_O = rd_q;
    assign EVEN_PARITY_CHOICE_O = par_q;
    assign UNIT_O = unit_q;
endmodule

// [testbench/tcu_drive_model.sv]
// Tape transport stand-in that answers only to its own drive number
`timescale 1ns/10ps
module tcu_drive_model #(parameter logic [2:0] PLUG = 3'h5) (
    input wire logic [2:0] unit_i, // Drive number
    input wire logic clr_i, // Master clear
    output logic sel_o // Transport selected
);
    assign sel_o = unit_i == PLUG && !clr_i;
endmodule

// [testbench/tcu_cmd_upper_properties.sv]
// Checker for the tape command word upper byte
`timescale 1ns/10ps
module tcu_cmd_upper_chk (
    input wire logic SYS_CLK_I, // Clock
    input wire logic RESETN_I, // Bus initialize
    input wire logic WR_HI_I, // Upper byte write
    input wire logic START_I, // Start command
    input wire logic CHECK_CHAR_I, // Check character read
    input wire logic IRQ_PERMIT_I, // Interrupt enable
    input wire logic CONTROLLER_IDLE_I, // Controller ready
    input wire logic ILLEGAL_COMMAND_FLAG_I, // Illegal command
    input wire logic [15:8] WDATA_I, // Write data
    input wire logic [15:8] RDATA_O, // Read data
    input wire logic [8:0] ERR_NOW_I, // Immediate errors
    input wire logic IRQ_O, // Interrupt request
    input wire logic MASTER_CLEAR_STROBE_O // Clear strobe
);
    import tcu_pkg::*;
    default clocking @(posedge SYS_CLK_I); endclocking
    default disable iff (!RESETN_I);
    logic [5:0] hi_q, hi_d;
    logic wr_ok;
    assign wr_ok = WR_HI_I && !WDATA_I[12] && !MASTER_CLEAR_STROBE_O;
    always_comb hi_d = (!RESETN_I || !MASTER_CLEAR_STROBE_O) ? 6'h00 : hi_q + 6'h01;
    always_ff @(posedge SYS_CLK_I) hi_q <= hi_d;
    property p_rd0; RDATA_O[12] == 1'b0; endproperty
    a_rd0: assert property (p_rd0) else $error("clear bit reads one");
    property p_crise; WR_HI_I && WDATA_I[12] && !MASTER_CLEAR_STROBE_O |=> MASTER_CLEAR_STROBE_O; endproperty
    a_crise: assert property (p_crise) else $error("no clear strobe");
    property p_clen; $fell(MASTER_CLEAR_STROBE_O) && $past(RESETN_I) |-> hi_q == CLR_CNT_W_MAX; endproperty
    a_clen: assert property (p_clen) else $error("clear strobe length");
    property p_cfld; MASTER_CLEAR_STROBE_O ##1 MASTER_CLEAR_STROBE_O |-> RDATA_O[14:8] == 7'h00; endproperty
    a_cfld: assert property (p_cfld) else $error("fields kept in clear");
    property p_rdbk; wr_ok |=> RDATA_O[14:8] == {$past(WDATA_I[14:13]), 1'b0, $past(WDATA_I[11:8])}; endproperty
    a_rdbk: assert property (p_rdbk) else $error("readback mismatch");
    property p_irq; IRQ_O |-> IRQ_PERMIT_I && (CONTROLLER_IDLE_I || ILLEGAL_COMMAND_FLAG_I) ##1 RDATA_O[15]; endproperty
    a_irq: assert property (p_irq) else $error("irq not qualified");
    property p_enow; ERR_NOW_I != 9'h000 && !MASTER_CLEAR_STROBE_O |=> RDATA_O[15]; endproperty
    a_enow: assert property (p_enow) else $error("summary not set");
    property p_start; START_I && ERR_NOW_I == 9'h000 && !CHECK_CHAR_I |=> !RDATA_O[15]; endproperty
    a_start: assert property (p_start) else $error("summary not cleared");
    c_clr: cover property (MASTER_CLEAR_STROBE_O ##1 !MASTER_CLEAR_STROBE_O);
    c_irq: cover property (IRQ_O);
    c_err: cover property (RDATA_O[15] ##1 !RDATA_O[15]);
endmodule
bind tcu_cmd_upper tcu_cmd_upper_chk u_chk (
    .SYS_CLK_I(SYS_CLK_I),
    .RESETN_I(RESETN_I),
    .WR_HI_I(WR_HI_I),
    .START_I(START_I),
    .CHECK_CHAR_I(CHECK_CHAR_I),
    .IRQ_PERMIT_I(IRQ_PERMIT_I),
    .CONTROLLER_IDLE_I(CONTROLLER_IDLE_I),
    .ILLEGAL_COMMAND_FLAG_I(ILLEGAL_COMMAND_FLAG_I),
    .WDATA_I(WDATA_I),
    .RDATA_O(RDATA_O),
    .ERR_NOW_I(ERR_NOW_I),
    .IRQ_O(IRQ_O),
    .MASTER_CLEAR_STROBE_O(MASTER_CLEAR_STROBE_O)
);

// [testbench/tcu_cmd_upper_tb.sv]
// Testbench for the tape command word upper byte
`timescale 1ns/10ps
`define CHK(a, e) begin cmp_count++; if ((a) !== (e)) begin miscompares++; $display("[FAIL] %0t got %h exp %h", $time, a, e); end end
module tcu_cmd_upper_tb;
    import tcu_pkg::*;
    logic SYS_CLK_I = 0, RESETN_I = 0, WR_HI_I = 0, START_I = 0, IRQ_PERMIT_I = 1, CONTROLLER_IDLE_I = 1;
    logic ILLEGAL_COMMAND_FLAG_I = 0, CHECK_CHAR_I = 0, SEVEN_TRACK_FLAG_I = 0, TAPE_MOVING_I = 0, PARITY_ERR_I = 0;
    logic [15:8] WDATA_I = 8'h00, RDATA_O;
    logic [8:0] ERR_NOW_I = 9'h000, ERR_DEFER_I = 9'h000;
    logic [2:0] FUNCTION_I = 3'h0, UNIT_O;
    logic [3:0] DENSITY_O;
    logic IRQ_O, PARITY_ERR_O, EVEN_PARITY_CHOICE_O, MASTER_CLEAR_STROBE_O, sel;
    logic [3:0] tbl [4] = '{4'hd, 4'hb, 4'h8, 4'h6};
    int miscompares = 0, cmp_count = 0, n;
    tcu_cmd_upper uut (
        .SYS_CLK_I(SYS_CLK_I),
        .RESETN_I(RESETN_I),
        .WR_HI_I(WR_HI_I),
        .WDATA_I(WDATA_I),
        .RDATA_O(RDATA_O),
        .START_I(START_I),
        .IRQ_PERMIT_I(IRQ_PERMIT_I),
        .CONTROLLER_IDLE_I(CONTROLLER_IDLE_I),
        .ILLEGAL_COMMAND_FLAG_I(ILLEGAL_COMMAND_FLAG_I),
        .ERR_NOW_I(ERR_NOW_I),
        .ERR_DEFER_I(ERR_DEFER_I),
        .CHECK_CHAR_I(CHECK_CHAR_I),
        .SEVEN_TRACK_FLAG_I(SEVEN_TRACK_FLAG_I),
        .TAPE_MOVING_I(TAPE_MOVING_I),
        .FUNCTION_I(FUNCTION_I),
        .PARITY_ERR_I(PARITY_ERR_I),
        .IRQ_O(IRQ_O),
        .PARITY_ERR_O(PARITY_ERR_O),
        .DENSITY_O(DENSITY_O),
        .EVEN_PARITY_CHOICE_O(EVEN_PARITY_CHOICE_O),
        .UNIT_O(UNIT_O),
        .MASTER_CLEAR_STROBE_O(MASTER_CLEAR_STROBE_O)
    );
    tcu_drive_model drv (.unit_i(UNIT_O), .clr_i(MASTER_CLEAR_STROBE_O), .sel_o(sel));
    always #12.5 SYS_CLK_I = ~SYS_CLK_I;
    task automatic cyc(int k);
        repeat (k) @(posedge SYS_CLK_I);
        #1;
    endtask
    task automatic wr(logic [15:8] d);
        @(posedge SYS_CLK_I);
        WR_HI_I <= 1'b1;
        WDATA_I <= d;
        @(posedge SYS_CLK_I);
        WR_HI_I <= 1'b0;
        #1;
    endtask
    task automatic err_pulse(logic [8:0] e, logic exp);
        @(posedge SYS_CLK_I);
        ERR_NOW_I <= e;
        #1;
        `CHK(IRQ_O, exp)
        @(posedge SYS_CLK_I);
        ERR_NOW_I <= 9'h000;
        START_I <= 1'b1;
        #1;
        `CHK(RDATA_O[15], 1'b1)
        @(posedge SYS_CLK_I);
        START_I <= 1'b0;
        #1;
        `CHK(RDATA_O[15], 1'b0)
    endtask
    task automatic close_out;
        $display("compares %0d mismatches %0d", cmp_count, miscompares);
        if (miscompares == 0 && cmp_count > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    // Hang guard at 800 cycles, far beyond the roughly 100 cycles of the run
    initial begin
        #20000;
        miscompares++;
        close_out();
    end
    initial begin
        repeat (3) @(posedge SYS_CLK_I);
        RESETN_I <= 1'b1;
        cyc(1);
        `CHK({RDATA_O, DENSITY_O}, 12'h001)
        for (int d = 0; d < 4; d++) begin
            wr({1'b0, 2'(d), 2'h1, 3'h5});
            `CHK(RDATA_O, {1'b0, 2'(d), 2'h1, 3'h5})
            `CHK(DENSITY_O, 4'(d == 3 ? 4 : 1 << d))
            `CHK({EVEN_PARITY_CHOICE_O, UNIT_O, sel}, 5'h1b)
        end
        @(posedge SYS_CLK_I);
        SEVEN_TRACK_FLAG_I <= 1'b1;
        wr(8'h60);
        `CHK(DENSITY_O, DENS_DUMP)
        `CHK(EVEN_PARITY_CHOICE_O, 1'b0)
        wr(8'h00);
        `CHK({RDATA_O, EVEN_PARITY_CHOICE_O, UNIT_O, sel}, 13'h0000)
        wr(8'h7f);
        n = 0;
        `CHK(RDATA_O[12], 1'b0)
        while (MASTER_CLEAR_STROBE_O === 1'b1 && n < 100) begin
            n++;
            cyc(1);
        end
        `CHK(n, CLR_PULSE_CYC)
        `CHK(RDATA_O, 8'h00)
        foreach (tbl[k]) begin
            @(posedge SYS_CLK_I);
            {IRQ_PERMIT_I, CONTROLLER_IDLE_I, ILLEGAL_COMMAND_FLAG_I} <= tbl[k][3:1];
            err_pulse(9'h001 << (2 * k), tbl[k][0]);
        end
        @(posedge SYS_CLK_I);
        ERR_DEFER_I <= 9'h010;
        @(posedge SYS_CLK_I);
        ERR_DEFER_I <= 9'h000;
        cyc(2);
        `CHK(RDATA_O[15], 1'b0)
        @(posedge SYS_CLK_I);
        CHECK_CHAR_I <= 1'b1;
        @(posedge SYS_CLK_I);
        CHECK_CHAR_I <= 1'b0;
        #1;
        `CHK(RDATA_O[15], 1'b1)
        @(posedge SYS_CLK_I);
        ERR_NOW_I <= 9'h100;
        START_I <= 1'b1;
        @(posedge SYS_CLK_I);
        ERR_NOW_I <= 9'h000;
        #1;
        `CHK(RDATA_O[15], 1'b1)
        @(posedge SYS_CLK_I);
        START_I <= 1'b0;
        #1;
        `CHK(RDATA_O[15], 1'b0)
        @(posedge SYS_CLK_I);
        PARITY_ERR_I <= 1'b1;
        for (int f = 0; f < 16; f++) begin
            @(posedge SYS_CLK_I);
            {TAPE_MOVING_I, FUNCTION_I} <= 4'(f);
            #1;
            `CHK(PARITY_ERR_O, f > 7 && !(f inside {12, 13, 15}))
        end
        close_out();
    end
endmodule
